// file: bench/dihs_issue_ctrl_tb.sv
// Purpose: self-checking bench for issue pairing and hazard spacing
// Assumes: slot1 shifts into slot0 after slot0 issues alone
// Notes:   each spacing case starts from a fresh reset
module dihs_issue_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dihs_pkg::*;
  typedef struct packed {
    dihs_group_t grp; dihs_op_t op;
    logic dbl, fpd, sae, sbe, de;
    logic [5:0] sa, sb, d;
    logic [4:0] rate, lat, wb, lkc;
    logic [3:0] res, lock;
  } dihs_tb_ins_t;
  logic            clock = 0;
  logic            rst = 1;
  logic            v0 = 0;
  logic            v1 = 0;
  logic            go = 0;
  logic [3:0]      fl = 0;
  logic [3:0]      dl = 0;
  logic            fetch_stall, data_wait, issue0, issue1, pair_reg;
  dihs_state_t     state_out;
  logic [3:0]      stage_occ;
  dihs_tb_ins_t    sl0 = '0;
  dihs_tb_ins_t    sl1 = '0;
  dihs_tb_ins_t    a, b;
  int              err_count = 0;
  int              n_checks = 0;
  int              r, n;

  always #10 clock = ~clock;

  dihs_mem_model dihs_mem_model_inst (.clock(clock), .rst(rst), .go(go), .fetch_len(fl), .data_len(dl),
    .fetch_stall(fetch_stall), .data_wait(data_wait));

  dihs_issue_ctrl dihs_issue_ctrl_inst (.clock(clock), .rst(rst), .fetch_stall(fetch_stall),
    .data_wait(data_wait), .s0_valid(v0), .s0_group(sl0.grp), .s0_op(sl0.op), .s0_dbl(sl0.dbl),
    .s0_fp_dst(sl0.fpd), .s0_src_a(sl0.sa), .s0_src_a_en(sl0.sae), .s0_src_b(sl0.sb),
    .s0_src_b_en(sl0.sbe), .s0_dst(sl0.d), .s0_dst_en(sl0.de), .s0_rate(sl0.rate), .s0_lat(sl0.lat),
    .s0_wb_lat(sl0.wb), .s0_res(sl0.res), .s0_lock(sl0.lock), .s0_lock_cyc(sl0.lkc),
    .s1_valid(v1), .s1_group(sl1.grp), .s1_op(sl1.op), .s1_dbl(sl1.dbl), .s1_fp_dst(sl1.fpd),
    .s1_src_a(sl1.sa), .s1_src_a_en(sl1.sae), .s1_src_b(sl1.sb), .s1_src_b_en(sl1.sbe),
    .s1_dst(sl1.d), .s1_dst_en(sl1.de), .s1_rate(sl1.rate), .s1_lat(sl1.lat), .s1_wb_lat(sl1.wb),
    .s1_res(sl1.res), .s1_lock(sl1.lock), .s1_lock_cyc(sl1.lkc), .issue0(issue0), .issue1(issue1),
    .pair_reg(pair_reg), .state_out(state_out), .stage_occ(stage_occ));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  function automatic dihs_tb_ins_t mk(dihs_group_t g, dihs_op_t o, int l);
    mk = '0;
    mk.grp = g;
    mk.op = o;
    mk.rate = 5'h01;
    mk.lat = l[4:0];
    mk.wb = l[4:0];
  endfunction : mk

  // bench model of the pairing table
  function automatic logic pair_ok(dihs_group_t x, dihs_group_t y);
    if (x == non_pairable_group || y == non_pairable_group) return 1'b0;
    return (x != y) || (x == move_test_group);
  endfunction : pair_ok

  task automatic do_reset;
    rst = 1;
    v0 = 0;
    v1 = 0;
    repeat (4) @(posedge clock);
    #1 rst = 0;
  endtask : do_reset

  // older issues alone, younger moves up and must wait e cycles
  task automatic chain(input dihs_tb_ins_t x, input dihs_tb_ins_t y, input int e, input int f, input int d,
                       input dihs_state_t st);
    int k;
    do_reset;
    sl0 = x;
    sl1 = y;
    v0 = 1;
    v1 = 1;
    @(negedge clock);
    check(issue0, 1);
    check(issue1, 0);
    @(posedge clock);
    #1 sl0 = y;
    v1 = 0;
    fl = f[3:0];
    dl = d[3:0];
    go = (f + d) > 0;
    for (k = 1; k <= e; k++) begin
      @(negedge clock);
      check(issue0, k == e);
      if (k == 1) check(stage_occ, 4'h1);
      if (k == 1) check(pair_reg, 0);
      if (k == 3) check(state_out, st);
      if (k == 3) check(stage_occ, (d > 0) ? 4'h2 : 4'h4);
      if (k < e) begin
        @(posedge clock);
        #1 go = 0;
      end
    end
    @(posedge clock);
    #1 v0 = 0;
    go = 0;
  endtask : chain

  initial begin
    #100us;
    err_count++;
    give_verdict;
  end

  initial begin
    void'($urandom(32'hA4611F34));
    do_reset;
    for (int g0 = 0; g0 < 6; g0++) begin
      for (int g1 = 0; g1 < 6; g1++) begin
        sl0 = mk(dihs_group_t'(g0[2:0]), op_other, 1);
        sl1 = mk(dihs_group_t'(g1[2:0]), op_other, 1);
        v0 = 1;
        v1 = 1;
        @(negedge clock);
        check(issue0, 1);
        check(issue1, pair_ok(sl0.grp, sl1.grp));
        @(posedge clock);
        #1 check(pair_reg, pair_ok(sl0.grp, sl1.grp));
      end
    end
    r = $urandom % 62 + 1;
    for (n = 2; n <= 5; n++) begin
      a = mk(load_store_group, op_load, n); a.d = r[5:0]; a.de = 1;
      b = mk(integer_alu_group, op_other, 1); b.sb = r[5:0]; b.sbe = 1;
      chain(a, b, n, 0, 0, st_run);
    end
    b.op = op_dyn_shift; b.sbe = 0; b.sa = r[5:0]; b.sae = 1;
    a = mk(load_store_group, op_load, 2); a.d = r[5:0]; a.de = 1;
    chain(a, b, a.lat + 1, 0, 0, st_run);
    a = mk(fp_arith_group, op_fp_dbl_asm, 5); a.fpd = 1; a.d = r[5:0]; a.de = 1;
    b = mk(load_store_group, op_fp_store, 1); b.sa = r[5:0]; b.sae = 1;
    chain(a, b, a.lat - 1, 0, 0, st_run);
    a = mk(load_store_group, op_other, 1); a.fpd = 1; a.d = r[5:0]; a.de = 1;
    b = mk(fp_arith_group, op_fp_inner, 4); b.sa = r[5:0]; b.sae = 1;
    chain(a, b, 2, 0, 0, st_run);
    a = mk(integer_alu_group, op_other, 1); a.rate = 5'h03;
    chain(a, mk(move_test_group, op_other, 1), 3, 0, 0, st_run);
    a = mk(fp_arith_group, op_fp_div_sqrt, 10); a.wb = 5'h0C; a.fpd = 1; a.d = r[5:0]; a.de = 1;
    b = mk(load_store_group, op_load, 2); b.d = r[5:0]; b.de = 1;
    chain(a, b, a.wb - 1, 0, 0, st_run);
    a.op = op_fp_dbl_asm; a.lat = 5'h06; a.wb = 5'h07;
    chain(a, b, a.wb - 2, 0, 0, st_run);
    a.op = op_fp_div_sqrt; a.d = 6'h3F; b.d = 6'h3F;
    chain(a, b, 1, 0, 0, st_run);
    a = mk(fp_arith_group, op_fp_mtrv, 7); a.sa = r[5:0]; a.sae = 1;
    b = mk(load_store_group, op_fp_wr_only, 1); b.d = r[5:0]; b.de = 1;
    chain(a, b, 5, 0, 0, st_run);
    a.op = op_fp_dbl_asm; a.dbl = 1;
    chain(a, b, 2, 0, 0, st_run);
    a.dbl = 0;
    chain(a, b, 1, 0, 0, st_run);
    a = mk(fp_arith_group, op_other, 1); a.res = 4'h2; a.lock = 4'h2; a.lkc = 5'h04;
    b = mk(load_store_group, op_other, 1); b.res = 4'h2;
    chain(a, b, 4, 0, 0, st_run);
    a.res = 4'h1; a.lock = 4'h1; a.lkc = 5'h03; b.res = 4'h1;
    chain(a, b, 3, 0, 0, st_run);
    a = mk(load_store_group, op_load, 3); a.d = r[5:0]; a.de = 1;
    b = mk(integer_alu_group, op_other, 1); b.sa = r[5:0]; b.sae = 1;
    n = $urandom % 4 + 1;
    chain(a, b, 3 + n, 0, n, st_frozen);
    chain(a, b, 6, 4, 0, st_fetch_wait);
    give_verdict;
  end
endmodule : dihs_issue_ctrl_tb

// file: bench/dihs_mem_model.sv
// Purpose: fetch and data memory side model driving the stall inputs
// Assumes: go is sampled on a rising edge, lengths in core cycles
// Notes:   zero length answers at once; longer lengths model slow memory
module dihs_mem_model (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       go,
  input  wire logic [3:0] fetch_len,
  input  wire logic [3:0] data_len,
  output logic            fetch_stall,
  output logic            data_wait
);
  timeunit 1ns;
  timeprecision 1ps;
  int fc;
  int dc;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      fc <= 0;
      dc <= 0;
    end else if (go) begin
      fc <= fetch_len;
      dc <= data_len;
    end else begin
      if (fc > 0) fc <= fc - 1;
      if (dc > 0) dc <= dc - 1;
    end
  end
  // outputs move just after the edge like any other driver
  assign #1 fetch_stall = (fc != 0);
  assign #1 data_wait   = (dc != 0);
endmodule : dihs_mem_model

// file: hdl/dihs_issue_ctrl.sv
// Purpose: dual issue decision, hazard stalls, fetch hold and data freeze
// Assumes: slot0 is the older fetched instruction; fetch shifts on issue
// Notes:   lock start offset is taken as the issue cycle
// What this block does
// RL1: every instruction carries one of six groups
// RL2: track decode, execute, access, write-back occupancy
// RL3: refuse pairing with non-pairable or same group
// RL4: pair different groups; two move-test may pair
// RL5: everything runs on the single core clock
// RL6: wait issue rate cycles before next issue
// RL7: stages never overlap except legal pairs
// RL8: read-after-write waits writer latency since issue
// RL9: write-after-write waits latency minus one or two
// RL10: write-after-read waits five or two cycles
// RL11: write-after-read only for listed fp pairs
// RL12: fp computation then fp store: latency minus one
// RL13: load before dynamic shift: latency plus one
// RL14: short latency before double fp raised to two
// RL15: write-after-write: fp arith then load-store
// RL16: write-after-write uses longest write-back latency
// RL17: never write-after-write stall on fp status register
// RL18: locked resource stalls its next user
// RL19: fetch penalty stops issue, execution continues
// RL20: data wait freezes all uncompleted instructions
// RL21: unpairable pair issues older alone first
// RL22: compare registers against all in-flight results
`include "dihs_params.svh"

module dihs_issue_ctrl #(
  parameter int RW   = `DIHS_RW,
  parameter int CW   = `DIHS_CW,
  parameter int NRES = `DIHS_NRES
) (
  input  logic                clock,
  input  logic                rst,
  input  logic                fetch_stall,
  input  logic                data_wait,
  input  logic                s0_valid,
  input  dihs_pkg::dihs_group_t s0_group,
  input  dihs_pkg::dihs_op_t  s0_op,
  input  logic                s0_dbl,
  input  logic                s0_fp_dst,
  input  logic [RW-1:0]       s0_src_a,
  input  logic                s0_src_a_en,
  input  logic [RW-1:0]       s0_src_b,
  input  logic                s0_src_b_en,
  input  logic [RW-1:0]       s0_dst,
  input  logic                s0_dst_en,
  input  logic [CW-1:0]       s0_rate,
  input  logic [CW-1:0]       s0_lat,
  input  logic [CW-1:0]       s0_wb_lat,
  input  logic [NRES-1:0]     s0_res,
  input  logic [NRES-1:0]     s0_lock,
  input  logic [CW-1:0]       s0_lock_cyc,
  input  logic                s1_valid,
  input  dihs_pkg::dihs_group_t s1_group,
  input  dihs_pkg::dihs_op_t  s1_op,
  input  logic                s1_dbl,
  input  logic                s1_fp_dst,
  input  logic [RW-1:0]       s1_src_a,
  input  logic                s1_src_a_en,
  input  logic [RW-1:0]       s1_src_b,
  input  logic                s1_src_b_en,
  input  logic [RW-1:0]       s1_dst,
  input  logic                s1_dst_en,
  input  logic [CW-1:0]       s1_rate,
  input  logic [CW-1:0]       s1_lat,
  input  logic [CW-1:0]       s1_wb_lat,
  input  logic [NRES-1:0]     s1_res,
  input  logic [NRES-1:0]     s1_lock,
  input  logic [CW-1:0]       s1_lock_cyc,
  output logic                issue0,
  output logic                issue1,
  output logic                pair_reg,
  output dihs_pkg::dihs_state_t state_out,
  output logic [`DIHS_STAGES-2:0] stage_occ
);
  import dihs_pkg::*;

  typedef struct packed {
    dihs_state_t               state;
    logic                      pair;
    logic [CW-1:0]             rate_cnt;
    logic [NRES-1:0][CW-1:0]   lock_cnt;
    logic [`DIHS_STAGES-2:0]   occ;
  } dihs_ctrl_t;

  dihs_ctrl_t st_reg;
  dihs_ctrl_t st_next;

  if (RW != `DIHS_RW || CW < 3 || NRES < 1) begin : g_bad
    $error("dihs_issue_ctrl: unsupported parameter values");
  end

  // count to load for a wait of x cycles
  function automatic logic [CW-1:0] cnt_of(input logic [CW-1:0] x);
    cnt_of = (x == '0) ? '0 : x - 1'b1;
  endfunction : cnt_of

  function automatic logic [CW-1:0] max2(input logic [CW-1:0] a,
                                         input logic [CW-1:0] b);
    max2 = (a > b) ? a : b;
  endfunction : max2

  function automatic logic can_pair(input dihs_group_t a, // see RL1
                                    input dihs_group_t b);
    if (a == non_pairable_group || b == non_pairable_group) begin
      can_pair = 1'b0; // see RL3
    end else begin
      can_pair = (a != b) || (a == move_test_group); // see RL4
    end
  endfunction : can_pair

  // effective flow latency given the next instruction in sequence
  function automatic logic [CW-1:0] eff_lat(
      input logic [CW-1:0] lat, input dihs_group_t grp,
      input dihs_op_t op, input logic fp_dst, input logic [RW-1:0] dst,
      input logic f_valid, input dihs_op_t f_op, input logic f_dbl,
      input logic f_reads, input logic [RW-1:0] f_src_a);
    logic [CW-1:0] l;
    l = lat;
    if (f_valid && f_reads && grp == fp_arith_group &&
        f_op == op_fp_store && l != '0) begin
      l = l - `DIHS_ST_ADJ; // see RL12
    end
    if (f_valid && op == op_load && f_op == op_dyn_shift &&
        f_src_a == dst) begin
      l = l + `DIHS_SHIFT_ADJ; // see RL13
    end
    if (f_valid && fp_dst && l < `DIHS_MIN_LAT_DBL &&
        (f_dbl || f_op == op_fp_inner || f_op == op_fp_mtrv)) begin
      l = `DIHS_MIN_LAT_DBL; // see RL14
    end
    eff_lat = l;
  endfunction : eff_lat

  // in-flight result checks for one candidate
  function automatic logic hazard(
      input dihs_group_t grp, input dihs_op_t op,
      input logic sa_en, input logic sb_en,
      input logic d_en, input logic [RW-1:0] dst,
      input logic [CW-1:0] raw_a, input logic [CW-1:0] raw_b,
      input logic [CW-1:0] waw_d, input logic [CW-1:0] war_d);
    logic h;
    h = (sa_en && raw_a != '0) || (sb_en && raw_b != '0); // see RL8 RL22
    if (grp == load_store_group && d_en && dst != `DIHS_FP_STATUS_CONTROL_REG_ID &&
        waw_d != '0) begin
      h = 1'b1; // see RL15 RL17
    end
    if (op == op_fp_wr_only && d_en && war_d != '0) begin
      h = 1'b1; // see RL11
    end
    hazard = h;
  endfunction : hazard

  logic [5:0][RW-1:0] rd_idx;
  logic [5:0][CW-1:0] raw_v;
  logic [5:0][CW-1:0] waw_v;
  logic [5:0][CW-1:0] war_v;
  logic [1:0]         raw_ld;
  logic [1:0][RW-1:0] dst_idx;
  logic [1:0][CW-1:0] raw_val;
  logic [1:0]         waw_ld;
  logic [1:0][CW-1:0] waw_val;
  logic [3:0]         war_ld;
  logic [3:0][RW-1:0] war_idx;
  logic [3:0][CW-1:0] war_val;
  logic [CW-1:0]      lat0;
  logic [CW-1:0]      war0;
  logic [CW-1:0]      war1;
  logic               hz0;
  logic               hz1;
  logic               dep01;
  logic               lk0;
  logic               lk1;

  assign rd_idx = {s1_dst, s1_src_b, s1_src_a, s0_dst, s0_src_b, s0_src_a};

  dihs_regtrack #(.NLD(2), .NRD(6)) u_raw (
    .clock  (clock),
    .rst    (rst),
    .hold   (data_wait),
    .ld_en  (raw_ld),
    .ld_idx (dst_idx),
    .ld_val (raw_val),
    .rd_idx (rd_idx),
    .rd_val (raw_v)
  );

  dihs_regtrack #(.NLD(2), .NRD(6)) u_waw (
    .clock  (clock),
    .rst    (rst),
    .hold   (data_wait),
    .ld_en  (waw_ld),
    .ld_idx (dst_idx),
    .ld_val (waw_val),
    .rd_idx (rd_idx),
    .rd_val (waw_v)
  );

  dihs_regtrack #(.NLD(4), .NRD(6)) u_war (
    .clock  (clock),
    .rst    (rst),
    .hold   (data_wait),
    .ld_en  (war_ld),
    .ld_idx (war_idx),
    .ld_val (war_val),
    .rd_idx (rd_idx),
    .rd_val (war_v)
  );

  function automatic logic locked(input logic [NRES-1:0] need,
                                  input logic [NRES-1:0][CW-1:0] cnt);
    logic b;
    b = 1'b0;
    for (int r = 0; r < NRES; r++) begin
      if (need[r] && cnt[r] != '0) begin
        b = 1'b1;
      end
    end
    locked = b;
  endfunction : locked

  function automatic logic [CW-1:0] war_amt(input dihs_op_t op);
    war_amt = (op == op_fp_mtrv) ? `DIHS_WAR_MTRV :
              (op == op_fp_dbl_asm) ? `DIHS_WAR_DBL : '0; // see RL10
  endfunction : war_amt

  function automatic logic [CW-1:0] waw_amt(input dihs_op_t op,
                                            input logic [CW-1:0] wb);
    logic [CW-1:0] adj;
    adj = (op == op_fp_div_sqrt) ? `DIHS_WAW_DIV_ADJ : `DIHS_WAW_FE_ADJ;
    waw_amt = (wb > adj) ? wb - adj : '0; // see RL9 RL16
  endfunction : waw_amt

  always_comb begin
    hz0 = hazard(s0_group, s0_op, s0_src_a_en, s0_src_b_en, s0_dst_en,
                 s0_dst, raw_v[0], raw_v[1], waw_v[2], war_v[2]);
    hz1 = hazard(s1_group, s1_op, s1_src_a_en, s1_src_b_en, s1_dst_en,
                 s1_dst, raw_v[3], raw_v[4], waw_v[5], war_v[5]);
    // a pair with a mutual register dependency is never dual issued
    dep01 = s0_dst_en && ((s1_src_a_en && s1_src_a == s0_dst) ||
            (s1_src_b_en && s1_src_b == s0_dst) ||
            (s1_dst_en && s1_dst == s0_dst));
    dep01 = dep01 || (s1_dst_en && ((s0_src_a_en && s0_src_a == s1_dst) ||
            (s0_src_b_en && s0_src_b == s1_dst)));
    lk0 = locked(s0_res, st_reg.lock_cnt); // see RL18
    lk1 = locked(s1_res, st_reg.lock_cnt) || ((s0_lock & s1_res) != '0);
    // see RL19 RL20 RL6
    issue0 = s0_valid && !fetch_stall && !data_wait &&
             st_reg.rate_cnt == '0 && !hz0 && !lk0;
    // see RL21 RL7
    issue1 = issue0 && s1_valid && s0_rate <= 5'h01 &&
             can_pair(s0_group, s1_group) && !dep01 && !hz1 && !lk1;
  end

  always_comb begin
    lat0 = eff_lat(s0_lat, s0_group, s0_op, s0_fp_dst, s0_dst, s1_valid,
                   s1_op, s1_dbl,
                   (s1_src_a_en && s1_src_a == s0_dst) ||
                   (s1_src_b_en && s1_src_b == s0_dst), s1_src_a);
    dst_idx = {s1_dst, s0_dst};
    raw_ld  = {issue1 && s1_dst_en, issue0 && s0_dst_en};
    raw_val = {cnt_of(s1_lat), cnt_of(lat0)};
    waw_ld  = {issue1 && s1_dst_en && s1_group == fp_arith_group &&
               s1_dst != `DIHS_FP_STATUS_CONTROL_REG_ID,
               issue0 && s0_dst_en && s0_group == fp_arith_group &&
               s0_dst != `DIHS_FP_STATUS_CONTROL_REG_ID}; // see RL15 RL17
    waw_val = {cnt_of(waw_amt(s1_op, s1_wb_lat)),
               cnt_of(waw_amt(s0_op, s0_wb_lat))};
    war0    = war_amt(s0_op);
    war1    = (s1_dbl || s1_op == op_fp_mtrv) ? war_amt(s1_op) : '0;
    if (!s0_dbl && s0_op == op_fp_dbl_asm) begin
      war0 = '0; // see RL11
    end
    war_idx = {s1_src_b, s1_src_a, s0_src_b, s0_src_a};
    war_ld  = {issue1 && s1_src_b_en && war1 != '0,
               issue1 && s1_src_a_en && war1 != '0,
               issue0 && s0_src_b_en && war0 != '0,
               issue0 && s0_src_a_en && war0 != '0};
    war_val = {cnt_of(war1), cnt_of(war1), cnt_of(war0), cnt_of(war0)};
  end

  always_comb begin
    st_next = st_reg;
    if (data_wait) begin
      st_next.state = st_frozen; // see RL20
    end else if (fetch_stall) begin
      st_next.state = st_fetch_wait; // see RL19
    end else begin
      st_next.state = st_run;
    end
    case (st_reg.state)
      // freeze is applied below, so the cycle after a wait still records its issue
      st_run, st_fetch_wait, st_frozen: begin
        st_next.occ = {st_reg.occ[`DIHS_STAGES-3:0], issue0}; // see RL2
      end
      default: begin
        st_next.occ = '0;
      end
    endcase
    if (data_wait) begin
      st_next.occ = st_reg.occ;
    end else begin
      if (st_reg.rate_cnt != '0) begin
        st_next.rate_cnt = st_reg.rate_cnt - 1'b1;
      end
      for (int r = 0; r < NRES; r++) begin
        if (st_reg.lock_cnt[r] != '0) begin
          st_next.lock_cnt[r] = st_reg.lock_cnt[r] - 1'b1;
        end
        // the issue cycle is the first locked cycle
        if (issue0 && s0_lock[r]) begin
          st_next.lock_cnt[r] = max2(st_next.lock_cnt[r], cnt_of(s0_lock_cyc));
        end
        if (issue1 && s1_lock[r]) begin
          st_next.lock_cnt[r] = max2(st_next.lock_cnt[r], cnt_of(s1_lock_cyc));
        end
      end
    end
    if (issue0) begin
      st_next.pair = issue1;
      st_next.rate_cnt = cnt_of(issue1 ? max2(s0_rate, s1_rate)
                                       : s0_rate); // see RL6
    end
  end

  // see RL5
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_reg <= '{state: st_run, pair: 1'b0, rate_cnt: '0,
                  lock_cnt: '0, occ: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign pair_reg  = st_reg.pair;
  assign state_out = st_reg.state;
  assign stage_occ = st_reg.occ;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_freeze_no_issue: assert property (data_wait |-> !issue0) // see RL20
    else $error("issue during data wait");
  chk_freeze_occ_hold: assert property (data_wait |=> $stable(stage_occ)) // see RL20
    else $error("stage occupancy moved while frozen");
  chk_fetch_no_issue: assert property (fetch_stall |-> !issue0) // see RL19
    else $error("issue during fetch penalty");
  chk_pair_nonpair: assert property (issue1 |-> s0_group != non_pairable_group
                                      && s1_group != non_pairable_group) // see RL3
    else $error("non-pairable instruction dual issued");
  chk_pair_same_grp: assert property (issue1 && s0_group == s1_group
                                      |-> s0_group == move_test_group) // see RL4
    else $error("same group pair other than move-test");
  chk_older_first: assert property (issue1 |-> issue0) // see RL21
    else $error("younger issued without older");
  chk_rate_gap: assert property (issue0 && !issue1 && s0_rate == 5'h03
                                 && !data_wait |=> !issue0 ##1 !issue0) // see RL6
    else $error("issue rate spacing violated");
  chk_raw_wait: assert property (issue0 && s0_dst_en && s0_lat == 5'h03 ##1 // see RL8
                                 s0_src_a_en && s0_src_a == $past(s0_dst)
                                 |-> !issue0)
    else $error("flow dependent issue too early");
  chk_lock_hold: assert property (issue0 && !issue1 && s0_lock[0] &&
                                  s0_lock_cyc == 5'h03 && !data_wait
                                  |=> !(issue0 && s0_res[0])) // see RL18
    else $error("locked resource used");

  cov_pair: cover property (issue0 && issue1);
  cov_fetch: cover property (fetch_stall && s0_valid);
  cov_freeze: cover property (data_wait ##1 data_wait ##1 !data_wait);

endmodule : dihs_issue_ctrl

// file: hdl/dihs_params.svh
// Purpose: named constants of the dual issue hazard and stall control
// Assumes: all counts are core clock cycles
// Notes:   counter values are wait cycles minus one
`ifndef DIHS_PARAMS_SVH
`define DIHS_PARAMS_SVH

`define DIHS_RW          6
`define DIHS_NREG        64
`define DIHS_CW          5
`define DIHS_NRES        4
`define DIHS_STAGES      5
`define DIHS_FP_STATUS_CONTROL_REG_ID    6'h3F
`define DIHS_WAW_DIV_ADJ 5'h01
`define DIHS_WAW_FE_ADJ  5'h02
`define DIHS_WAR_MTRV    5'h05
`define DIHS_WAR_DBL     5'h02
`define DIHS_ST_ADJ      5'h01
`define DIHS_SHIFT_ADJ   5'h01
`define DIHS_MIN_LAT_DBL 5'h02

`endif

// file: hdl/dihs_pkg.sv
// Purpose: types shared by the issue control and its register tracker
// Assumes: decode supplies group and operation class per slot
// Notes:   group codes follow the pairing table order
package dihs_pkg;

  typedef enum logic [2:0] {
    move_test_group     = 3'h0,
    integer_alu_group   = 3'h1,
    jump_class_group    = 3'h2,
    load_store_group    = 3'h3,
    fp_arith_group      = 3'h4,
    non_pairable_group  = 3'h5
  } dihs_group_t;

  typedef enum logic [3:0] {
    op_other       = 4'h0,
    op_fp_div_sqrt = 4'h1,
    op_fp_dbl_asm  = 4'h2,
    op_fp_mtrv     = 4'h3,
    op_fp_wr_only  = 4'h4,
    op_load        = 4'h5,
    op_dyn_shift   = 4'h6,
    op_fp_store    = 4'h7,
    op_fp_inner    = 4'h8
  } dihs_op_t;

  typedef enum logic [2:0] {
    st_run        = 3'h1,
    st_fetch_wait = 3'h2,
    st_frozen     = 3'h4
  } dihs_state_t;

endpackage : dihs_pkg

// file: hdl/dihs_regtrack.sv
// Purpose: per register countdown table for hazard spacing
// Assumes: loads only happen while hold is low
// Notes:   a load keeps the larger of old and new count
`include "dihs_params.svh"

module dihs_regtrack #(
  parameter int NREG = `DIHS_NREG,
  parameter int RW   = `DIHS_RW,
  parameter int CW   = `DIHS_CW,
  parameter int NLD  = 2,
  parameter int NRD  = 6
) (
  input  logic                     clock,
  input  logic                     rst,
  input  logic                     hold,
  input  logic [NLD-1:0]           ld_en,
  input  logic [NLD-1:0][RW-1:0]   ld_idx,
  input  logic [NLD-1:0][CW-1:0]   ld_val,
  input  logic [NRD-1:0][RW-1:0]   rd_idx,
  output logic [NRD-1:0][CW-1:0]   rd_val
);
  import dihs_pkg::*;

  typedef struct packed {
    logic [NREG-1:0][CW-1:0] cnt;
  } dihs_trk_t;

  dihs_trk_t st_reg;
  dihs_trk_t st_next;

  if (NREG != (1 << RW)) begin : g_bad
    $error("dihs_regtrack: NREG must equal 2**RW");
  end

  always_comb begin
    st_next = st_reg;
    for (int i = 0; i < NREG; i++) begin
      if (!hold && st_reg.cnt[i] != '0) begin
        st_next.cnt[i] = st_reg.cnt[i] - 1'b1;
      end
    end
    for (int k = 0; k < NLD; k++) begin
      if (ld_en[k] && ld_val[k] > st_next.cnt[ld_idx[k]]) begin
        st_next.cnt[ld_idx[k]] = ld_val[k];
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // read data are flop contents, only the select is combinational
  always_comb begin
    for (int j = 0; j < NRD; j++) begin
      rd_val[j] = st_reg.cnt[rd_idx[j]];
    end
  end

endmodule : dihs_regtrack
